// File: inc/tx_seg_defs.vh
// Purpose: Offsets, field positions, reset values and widths of the transmit segmentation registers.
// Assumes: 16-bit register port with byte addresses.
// Notes: Definitions only.
`ifndef TX_SEG_DEFS_VH
`define TX_SEG_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_W 16
`define DATA_W 16
`define OFS_TX_ENGINE_CONTROL 16'h2000
`define OFS_TX_ENGINE_STATUS 16'h2002
`define OFS_CELL_FIFO_WRITE_POINTER 16'h2052
`define OFS_READ_POINTER_REGISTER 16'h2054
`define OFS_IRQ_STATUS 16'h2060
`define OFS_IRQ_MASK 16'h2062

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTL_SCHED_A_ENABLE 0
`define CTL_SCHED_B_ENABLE 1
`define CTL_SCHED_C_ENABLE 2
`define CTL_TX_CELL_FIFO_ENABLE 3
`define CTL_IDLE_DATA_CELL_AUTO_SEND 4
`define CTL_FIFO_OVERRUN_IRQ_ENABLE 5
`define CTL_TIMING_OVERLOAD_IRQ_ENABLE 6
`define CTL_READ_POINTER_STEP 7
`define CTL_FORCE_STATUS_EVENTS 8
`define CTL_STORED_MSB 8
`define CTL_RESET 9'h000

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define STS_FIFO_OVERRUN_FLAG 5
`define STS_TIMING_OVERLOAD_ERROR 6
`define STS_TX_SERVICE_SUMMARY 15
`define STS_FLAG_COUNT 2
`define STS_FLAG_RESET 2'h0

// ----------------------------------------------------------------------
// Interrupt status and mask fields
// ----------------------------------------------------------------------
`define IRQ_OVERRUN 0
`define IRQ_OVERLOAD 1
`define IRQ_CELL_SENT 2
`define IRQ_COUNT 3
`define IRQ_RESET 3'h0

// ----------------------------------------------------------------------
// Cell FIFO pointers
// ----------------------------------------------------------------------
`define PTR_W 8
`define PTR_RESET 8'h00
`define PTR_ONE 8'h01
`define RD_ZERO 16'h0000

`endif

// File: verification/tb_tx_segmentation_control_status.sv
// Purpose: Register-level test of the transmit segmentation registers.
// Assumes: Strobe register port, read data one cycle after the strobe.
// Notes: No random stimulus.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb_tx_segmentation_control_status;
  logic sys_clk = 0;
  logic arst_n = 0;
  logic [15:0] regAddr = 0;
  logic [15:0] regWrData = 0;
  logic regWr = 0;
  logic regRd = 0;
  logic engineIdle = 1;
  logic schedDataReq = 0;
  logic engineOverload = 0;
  wire [15:0] regRdData;
  wire [7:0] cellFifoReadPointer;
  wire [7:0] cellFifoWritePointer;
  wire schedAEnable, schedBEnable, schedCEnable, txCellFifoEnable, idleDataCellAutoSend;
  wire dataCellSend, topLevelTxService, irq;
  int n_errors = 0;
  int cmp_count = 0;
  always #2.5 sys_clk = ~sys_clk;
  tx_segmentation_control_status i_tx_segmentation_control_status (.sys_clk, .arst_n, .regAddr, .regWrData,
    .regWr, .regRd, .regRdData, .engineIdle, .schedDataReq, .engineOverload, .schedAEnable, .schedBEnable,
    .schedCEnable, .txCellFifoEnable, .idleDataCellAutoSend, .cellFifoReadPointer, .cellFifoWritePointer,
    .dataCellSend, .topLevelTxService, .irq);
  task automatic give_verdict;
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic settle;
    tick(2);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [15:0] ex);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    `CHK("regRdData", ex, regRdData)
  endtask
  task automatic waitPtr(input logic [7:0] p);
    int k = 0;
    #1;
    while (cellFifoReadPointer !== p && k < 60) begin
      tick(1);
      #1;
      k++;
    end
    `CHK("cellFifoReadPointer", p, cellFifoReadPointer)
    if (cellFifoReadPointer !== p) begin
      give_verdict();
    end
  endtask
  initial begin
    tick(4);
    arst_n <= 1'b1;
    tick(3);
    rdc(16'h2000, 16'h0000);
    rdc(16'h2002, 16'h0000);
    #1;
    `CHK("ctrlOut", 5'h00, {idleDataCellAutoSend, txCellFifoEnable, schedCEnable, schedBEnable, schedAEnable})
    for (int i = 0; i < 3; i++) begin
      wr(16'h2000, 16'h0001 << i);
      #1;
      `CHK("schedEnables", 3'h1 << i, {schedCEnable, schedBEnable, schedAEnable})
    end
    wr(16'h2000, 16'hfe77);
    rdc(16'h2000, 16'h0077);
    wr(16'h2052, 16'h0005);
    #1;
    `CHK("cellFifoWritePointer", 8'h05, cellFifoWritePointer)
    rdc(16'h2052, 16'h0005);
    wr(16'h2000, 16'h0068);
    settle();
    tick(8);
    #1;
    `CHK("rdPtrNoReq", 8'h00, cellFifoReadPointer)
    @(posedge sys_clk);
    schedDataReq <= 1'b1;
    waitPtr(8'h05);
    @(posedge sys_clk);
    schedDataReq <= 1'b0;
    rdc(16'h2054, 16'h0005);
    wr(16'h2052, 16'h0005);
    settle();
    `CHK("topLevelTxService", 1'b1, topLevelTxService)
    rdc(16'h2002, 16'h8020);
    wr(16'h2002, 16'h0000);
    rdc(16'h2002, 16'h8020);
    wr(16'h2002, 16'h0020);
    rdc(16'h2002, 16'h0000);
    wr(16'h2000, 16'h00e8);
    settle();
    `CHK("rdPtrStep", 8'h06, cellFifoReadPointer)
    rdc(16'h2000, 16'h0068);
    wr(16'h2000, 16'h0060);
    settle();
    `CHK("rdPtrOff", 8'h00, cellFifoReadPointer)
    @(posedge sys_clk);
    engineIdle <= 1'b0;
    wr(16'h2000, 16'h0078);
    tick(6);
    #1;
    `CHK("rdPtrBusy", 8'h00, cellFifoReadPointer)
    `CHK("autoSendOut", 1'b1, idleDataCellAutoSend)
    @(posedge sys_clk);
    engineIdle <= 1'b1;
    waitPtr(8'h05);
    @(posedge sys_clk);
    engineOverload <= 1'b1;
    @(posedge sys_clk);
    engineOverload <= 1'b0;
    settle();
    `CHK("topLevelTxService", 1'b1, topLevelTxService)
    rdc(16'h2002, 16'h8040);
    wr(16'h2000, 16'h0038);
    settle();
    `CHK("topLevelTxService", 1'b0, topLevelTxService)
    wr(16'h2002, 16'h0040);
    rdc(16'h2002, 16'h0000);
    wr(16'h2000, 16'h0100);
    settle();
    rdc(16'h2002, 16'h8060);
    wr(16'h2000, 16'h0000);
    wr(16'h2002, 16'h0060);
    rdc(16'h2002, 16'h0000);
    wr(16'h2062, 16'h0000);
    settle();
    `CHK("irqMasked", 1'b0, irq)
    wr(16'h2062, 16'h0007);
    settle();
    `CHK("irqMask", 1'b1, irq)
    wr(16'h2060, 16'h0007);
    settle();
    `CHK("irqClear", 1'b0, irq)
    rdc(16'h2060, 16'h0000);
    wr(16'h2100, 16'hffff);
    rdc(16'h2100, 16'h0000);
    rdc(16'h2000, 16'h0000);
    give_verdict();
  end
endmodule
`default_nettype wire

// File: verification/tx_segmentation_control_status_props.sv
// Purpose: Port assertions for the transmit segmentation registers.
// Assumes: One clock; reset active low.
// Notes: Bound to the top module.
`timescale 1ns/1ps
`default_nettype none
`include "tx_seg_defs.vh"
module tx_segmentation_control_status_props (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [`ADDR_W-1:0] regAddr,
  input wire logic [`DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [`DATA_W-1:0] regRdData,
  input wire logic engineIdle,
  input wire logic schedDataReq,
  input wire logic schedAEnable,
  input wire logic schedBEnable,
  input wire logic schedCEnable,
  input wire logic txCellFifoEnable,
  input wire logic idleDataCellAutoSend,
  input wire logic [`PTR_W-1:0] cellFifoReadPointer,
  input wire logic [`PTR_W-1:0] cellFifoWritePointer,
  input wire logic dataCellSend
);
  wire logic reqSel = idleDataCellAutoSend ? engineIdle : schedDataReq;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  ctl_reserved_a: assert property (regRd && regAddr == 16'h2000 |=>
    regRdData[15:9] == 7'h00 && !regRdData[7]) else $error("control reserved bits set");
  sts_layout_a: assert property (regRd && regAddr == 16'h2002 |=>
    regRdData[4:0] == 5'h00 && regRdData[15] == (regRdData[5] | regRdData[6])) else $error("status layout wrong");
  ctl_write_a: assert property (regWr && regAddr == 16'h2000 |=>
    {idleDataCellAutoSend, txCellFifoEnable, schedCEnable, schedBEnable, schedAEnable} == $past(regWrData[4:0]))
    else $error("control outputs wrong");
  fifo_hold_a: assert property (!txCellFifoEnable && !$past(txCellFifoEnable) |-> cellFifoReadPointer == 8'h00)
    else $error("read pointer not held");
  send_gate_a: assert property (dataCellSend |-> $past(txCellFifoEnable) &&
    $past(cellFifoReadPointer) != $past(cellFifoWritePointer)) else $error("send from idle fifo");
  auto_sel_a: assert property (dataCellSend |-> $past(reqSel)) else $error("send without request");
  send_space_a: assert property (dataCellSend |=> !dataCellSend) else $error("sends too close");
  send_step_a: assert property (dataCellSend && !regWr && !$past(regWr) |=>
    cellFifoReadPointer == $past(cellFifoReadPointer) + 8'h01) else $error("pointer not stepped");
  send_c: cover property (dataCellSend);
  sts_rd_c: cover property (regRd && regAddr == 16'h2002);
  auto_c: cover property (dataCellSend && idleDataCellAutoSend);
endmodule
bind tx_segmentation_control_status tx_segmentation_control_status_props i_props (.sys_clk, .arst_n, .regAddr,
  .regWrData, .regWr, .regRd, .regRdData, .engineIdle, .schedDataReq, .schedAEnable, .schedBEnable, .schedCEnable,
  .txCellFifoEnable, .idleDataCellAutoSend, .cellFifoReadPointer, .cellFifoWritePointer, .dataCellSend);
`default_nettype wire

// File: verilog/sticky_bits.v
// Purpose: A row of sticky flags, set by hardware and cleared by writing a one.
// Assumes: Set and clear are single-cycle strobes on the same clock.
// Notes: A set in the cycle of a clear wins.
`timescale 1ns/1ps
`default_nettype none

module sticky_bits #(
  parameter WIDTH = 2
) (
  input wire clk,
  input wire rstN,
  input wire [WIDTH-1:0] setBits,
  input wire clrEn,
  input wire [WIDTH-1:0] clrBits,
  output reg [WIDTH-1:0] flags_q
);

  // ----------------------------------------------------------------------
  // Flag storage
  // ----------------------------------------------------------------------
  wire [WIDTH-1:0] flags_d;

  // The set term is applied last so an event is never lost to a clear.
  assign flags_d = (flags_q & ~(clrBits & {WIDTH{clrEn}})) | setBits;

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      flags_q <= {WIDTH{1'b0}};
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule
`default_nettype wire

// File: verilog/tx_segmentation_control_status.v
// Purpose: Control and status registers of the transmit segmentation engine.
// Assumes: All engine-side inputs are on sys_clk; the register port is a simple strobe port.
// Notes: Read data appear in the cycle after the read strobe and only there.
//
// Summary of operation
// R01 - Control bits 0, 1, 2 enable schedulers A, B, C; one enables.
// R02 - Software configures a scheduler fully before enabling it, keeps it fixed while enabled.
// R03 - Software re-initializes scheduler events after reconfiguring it, before restarting.
// R04 - FIFO enable bit 3 low holds the cell FIFO read pointer at zero.
// R05 - Auto-send bit 4 sends FIFO data cells when idle; otherwise schedulers decide.
// R06 - Overrun interrupt enable bit 5 lets the overrun flag raise top-level service.
// R07 - Overload interrupt enable bit 6 lets the overload flag raise top-level service.
// R08 - Writing one to control bit 7 steps the read pointer once, for test.
// R09 - Control bit 8 high forces every status event to occur, for test.
// R10 - Control bits 15 to 9 read as zero and ignore writes.
// R11 - Status bits 4 to 0 read as zero and ignore writes.
// R12 - Writing write pointer equal to read pointer latches the overrun flag, bit 5.
// R13 - Writing one clears the overrun flag; writing zero leaves it.
// R14 - Engine overload latches status bit 6; writing one clears it; fatal.
// R15 - Status bit 15 reads one while either status flag is set.
// R16 - All writable control bits clear to zero at reset.
`timescale 1ns/1ps
`default_nettype none
`include "tx_seg_defs.vh"

module tx_segmentation_control_status (
  input wire sys_clk,
  input wire arst_n,
  input wire [`ADDR_W-1:0] regAddr,
  input wire [`DATA_W-1:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [`DATA_W-1:0] regRdData,
  input wire engineIdle,
  input wire schedDataReq,
  input wire engineOverload,
  output reg schedAEnable,
  output reg schedBEnable,
  output reg schedCEnable,
  output reg txCellFifoEnable,
  output reg idleDataCellAutoSend,
  output reg [`PTR_W-1:0] cellFifoReadPointer,
  output reg [`PTR_W-1:0] cellFifoWritePointer,
  output reg dataCellSend,
  output reg topLevelTxService,
  output reg irq
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  reg rstMeta_q;
  reg rstN_q;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_q <= 1'b0;
      rstN_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN_q <= rstMeta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire selCtrl;
  wire selStat;
  wire selWptr;
  wire selRptr;
  wire selIrqStat;
  wire selIrqMask;
  wire wrCtrl;
  wire wrStat;
  wire wrWptr;
  wire wrIrqStat;
  wire wrIrqMask;

  assign selCtrl = (regAddr == `OFS_TX_ENGINE_CONTROL);
  assign selStat = (regAddr == `OFS_TX_ENGINE_STATUS);
  assign selWptr = (regAddr == `OFS_CELL_FIFO_WRITE_POINTER);
  assign selRptr = (regAddr == `OFS_READ_POINTER_REGISTER);
  assign selIrqStat = (regAddr == `OFS_IRQ_STATUS);
  assign selIrqMask = (regAddr == `OFS_IRQ_MASK);
  assign wrCtrl = regWr & selCtrl;
  assign wrStat = regWr & selStat;
  assign wrWptr = regWr & selWptr;
  assign wrIrqStat = regWr & selIrqStat;
  assign wrIrqMask = regWr & selIrqMask;

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  reg [`CTL_STORED_MSB:0] ctrl_q;
  reg [`CTL_STORED_MSB:0] ctrl_d;
  reg stepPtr_q;

  always @* begin
    ctrl_d = ctrl_q;
    if (wrCtrl) begin
      ctrl_d = regWrData[`CTL_STORED_MSB:0]; // [R01] [R10]
      ctrl_d[`CTL_READ_POINTER_STEP] = 1'b0;
    end
  end

  always @(posedge sys_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      ctrl_q <= `CTL_RESET; // [R16]
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Bit 7 is not stored; a written one becomes a single step strobe.
  always @(posedge sys_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      stepPtr_q <= 1'b0;
    end else begin
      stepPtr_q <= wrCtrl & regWrData[`CTL_READ_POINTER_STEP]; // [R08]
    end
  end

  wire fifoEn;
  wire autoSend;
  wire overrunIe;
  wire overloadIe;
  wire forceEvents;

  assign fifoEn = ctrl_q[`CTL_TX_CELL_FIFO_ENABLE];
  assign autoSend = ctrl_q[`CTL_IDLE_DATA_CELL_AUTO_SEND];
  assign overrunIe = ctrl_q[`CTL_FIFO_OVERRUN_IRQ_ENABLE];
  assign overloadIe = ctrl_q[`CTL_TIMING_OVERLOAD_IRQ_ENABLE];
  assign forceEvents = ctrl_q[`CTL_FORCE_STATUS_EVENTS];

  // ----------------------------------------------------------------------
  // Cell FIFO pointers
  // ----------------------------------------------------------------------
  reg [`PTR_W-1:0] rdPtr_q;
  reg [`PTR_W-1:0] rdPtr_d;
  reg [`PTR_W-1:0] wrPtr_q;
  reg [`PTR_W-1:0] wrPtr_d;
  reg sendCell_q;
  wire fifoEmpty;
  wire sendCell_d;
  wire overrunEvent;

  assign fifoEmpty = (rdPtr_q == wrPtr_q);
  assign overrunEvent = wrWptr & (regWrData[`PTR_W-1:0] == rdPtr_q); // [R12]

  // A cell leaves on an idle engine in auto mode, else only when a scheduler asks.
  assign sendCell_d = fifoEn & ~fifoEmpty & ~sendCell_q & (autoSend ? engineIdle : schedDataReq); // [R05]

  // A send and a test step in one cycle both count, so neither is lost.
  always @* begin
    rdPtr_d = rdPtr_q;
    if (!fifoEn) begin
      rdPtr_d = `PTR_RESET; // [R04]
    end else begin
      if (sendCell_q) begin
        rdPtr_d = rdPtr_d + `PTR_ONE; // [R05]
      end
      if (stepPtr_q) begin
        rdPtr_d = rdPtr_d + `PTR_ONE; // [R08]
      end
    end
  end

  always @* begin
    wrPtr_d = wrPtr_q;
    if (wrWptr) begin
      wrPtr_d = regWrData[`PTR_W-1:0];
    end
  end

  always @(posedge sys_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      rdPtr_q <= `PTR_RESET;
    end else begin
      rdPtr_q <= rdPtr_d;
    end
  end

  always @(posedge sys_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      wrPtr_q <= `PTR_RESET;
    end else begin
      wrPtr_q <= wrPtr_d;
    end
  end

  always @(posedge sys_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      sendCell_q <= 1'b0;
    end else begin
      sendCell_q <= sendCell_d;
    end
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  wire [`STS_FLAG_COUNT-1:0] statSet;
  wire [`STS_FLAG_COUNT-1:0] statClr;
  wire [`STS_FLAG_COUNT-1:0] statFlags;
  wire overrunFlag;
  wire overloadFlag;

  assign statSet[0] = overrunEvent | forceEvents; // [R12] [R09]
  assign statSet[1] = engineOverload | forceEvents; // [R14] [R09]
  assign statClr[0] = regWrData[`STS_FIFO_OVERRUN_FLAG]; // [R13]
  assign statClr[1] = regWrData[`STS_TIMING_OVERLOAD_ERROR]; // [R14]

  sticky_bits #(
    .WIDTH(`STS_FLAG_COUNT)
  ) statusFlags (
    .clk(sys_clk),
    .rstN(rstN_q),
    .setBits(statSet),
    .clrEn(wrStat),
    .clrBits(statClr),
    .flags_q(statFlags)
  );

  assign overrunFlag = statFlags[0];
  assign overloadFlag = statFlags[1];

  wire serviceSummary;
  wire topService_d;

  assign serviceSummary = overrunFlag | overloadFlag; // [R15]
  assign topService_d = (overrunFlag & overrunIe) | (overloadFlag & overloadIe); // [R06] [R07]

  always @(posedge sys_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      topLevelTxService <= 1'b0;
    end else begin
      topLevelTxService <= topService_d; // [R06] [R07]
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------------
  wire [`IRQ_COUNT-1:0] irqSet;
  wire [`IRQ_COUNT-1:0] irqFlags;
  reg [`IRQ_COUNT-1:0] irqMask_q;

  assign irqSet[`IRQ_OVERRUN] = statSet[0];
  assign irqSet[`IRQ_OVERLOAD] = statSet[1];
  assign irqSet[`IRQ_CELL_SENT] = sendCell_q;

  sticky_bits #(
    .WIDTH(`IRQ_COUNT)
  ) irqFlagRow (
    .clk(sys_clk),
    .rstN(rstN_q),
    .setBits(irqSet),
    .clrEn(wrIrqStat),
    .clrBits(regWrData[`IRQ_COUNT-1:0]),
    .flags_q(irqFlags)
  );

  always @(posedge sys_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      irqMask_q <= `IRQ_RESET;
    end else if (wrIrqMask) begin
      irqMask_q <= regWrData[`IRQ_COUNT-1:0];
    end
  end

  always @(posedge sys_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqFlags & irqMask_q);
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  reg [`DATA_W-1:0] rdData_d;

  always @* begin
    rdData_d = `RD_ZERO;
    if (regRd) begin
      if (selCtrl) begin
        rdData_d[`CTL_STORED_MSB:0] = ctrl_q; // [R10]
      end else if (selStat) begin
        rdData_d[`STS_FIFO_OVERRUN_FLAG] = overrunFlag; // [R11]
        rdData_d[`STS_TIMING_OVERLOAD_ERROR] = overloadFlag;
        rdData_d[`STS_TX_SERVICE_SUMMARY] = serviceSummary; // [R15]
      end else if (selWptr) begin
        rdData_d[`PTR_W-1:0] = wrPtr_q;
      end else if (selRptr) begin
        rdData_d[`PTR_W-1:0] = rdPtr_q;
      end else if (selIrqStat) begin
        rdData_d[`IRQ_COUNT-1:0] = irqFlags;
      end else if (selIrqMask) begin
        rdData_d[`IRQ_COUNT-1:0] = irqMask_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control mirrors
  // ----------------------------------------------------------------------
  always @(posedge sys_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      schedAEnable <= 1'b0;
      schedBEnable <= 1'b0;
      schedCEnable <= 1'b0;
      txCellFifoEnable <= 1'b0;
      idleDataCellAutoSend <= 1'b0;
    end else begin
      schedAEnable <= ctrl_d[`CTL_SCHED_A_ENABLE]; // [R01]
      schedBEnable <= ctrl_d[`CTL_SCHED_B_ENABLE]; // [R01]
      schedCEnable <= ctrl_d[`CTL_SCHED_C_ENABLE]; // [R01]
      txCellFifoEnable <= ctrl_d[`CTL_TX_CELL_FIFO_ENABLE];
      idleDataCellAutoSend <= ctrl_d[`CTL_IDLE_DATA_CELL_AUTO_SEND];
    end
  end

  // ----------------------------------------------------------------------
  // Pointer and send mirrors
  // ----------------------------------------------------------------------
  always @(posedge sys_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      cellFifoReadPointer <= `PTR_RESET;
      cellFifoWritePointer <= `PTR_RESET;
      dataCellSend <= 1'b0;
    end else begin
      cellFifoReadPointer <= rdPtr_d;
      cellFifoWritePointer <= wrPtr_d;
      dataCellSend <= sendCell_d;
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always @(posedge sys_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      regRdData <= `RD_ZERO;
    end else begin
      regRdData <= rdData_d;
    end
  end

endmodule
`default_nettype wire
